//--- mmd_top.sv
// mmd_top.sv: memory map decoder with control registers, internal RAM and region selects
//
// Notes on behaviour
// - a 20-bit address spans one megabyte, 00000h to FFFFFh
// - program ROM ends at 0FFFFh; 48 Kbyte spans 04000h to 0FFFFh
// - 0FFDCh to 0FFFFh is the fixed interrupt vector table
// - RAM starts at 00400h; 2.5 Kbyte spans 00400h to 00DFFh
// - RAM holds data, call frames and interrupt stack pushes
// - 00000h to 002FFh decodes to the control register area
// - unassigned control register offsets are reserved and hold nothing
// - data flash decodes 02400h to 02BFFh as two 1 Kbyte blocks
//
// Design decision made here: the strobed register port.
`default_nettype none

module mmd_top
  import mmd_pkg::*;
#(
  parameter logic [19:0] ROM_BASE   = MMD_ROM_BASE_DEF,
  parameter logic [19:0] RAM_END    = MMD_RAM_END_DEF,
  parameter bit          HAS_DFLASH = 1'b1,
  parameter logic [7:0]  TRIM_RESET = 8'h00
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [19:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  output logic [7:0]       cpu_rdata,
  input  wire logic [7:0]  rom_rdata,
  input  wire logic [7:0]  dfl_rdata,
  output logic             sel_sfr,
  output logic             sel_ram,
  output logic             sel_dfl,
  output logic             sel_rom,
  output logic             sel_vector,
  output logic             dfl_blk_b,
  output logic             dfl_wr,
  output logic [10:0]      dfl_addr,
  output logic [7:0]       dfl_wdata,
  output logic             match0,
  output logic             match1,
  output logic             emu_access
);

  localparam int RAM_BYTES = int'(RAM_END - MMD_RAM_BASE) + 1;
  localparam int RAM_AW    = $clog2(RAM_BYTES);

  // ----------------------------------------------------------------
  // internal bus and parts
  // ----------------------------------------------------------------
  mmd_bus_if bus ();
  assign bus.addr  = cpu_addr;
  assign bus.wdata = cpu_wdata;
  assign bus.wr    = cpu_wr;
  assign bus.rd    = cpu_rd;

  mmd_region_e             region;
  logic                    vector;
  logic                    emu_area;
  logic                    sfr_hit;
  logic [7:0]              sfr_rdata;
  logic [MMD_SFR_N*8-1:0]  sfr_regs;

  mmd_region_dec #(
    .ROM_BASE   (ROM_BASE),
    .RAM_END    (RAM_END),
    .HAS_DFLASH (HAS_DFLASH)
  ) u_dec (
    .bus      (bus),
    .region   (region),
    .vector   (vector),
    .emu_area (emu_area)
  );

  mmd_sfr_bank #(
    .TRIM_RESET (TRIM_RESET)
  ) u_sfr (
    .clk   (clk),
    .rst   (rst),
    .bus   (bus),
    .hit   (sfr_hit),
    .rdata (sfr_rdata),
    .regs  (sfr_regs)
  );

  // ----------------------------------------------------------------
  // access qualification
  // ----------------------------------------------------------------
  logic        access;
  logic        status_hit;
  logic        reserved;
  logic [19:0] ram_off;
  logic [19:0] dfl_off;
  logic [19:0] match0_addr;
  logic [19:0] match1_addr;
  logic [7:0]  match_en;

  assign access      = cpu_wr | cpu_rd;
  assign status_hit  = (cpu_addr == {10'h000, MMD_OFF_STATUS});
  // reserved covers blank map areas and empty control offsets alike
  assign reserved    = (region == MMD_RGN_NONE) ||
                       (region == MMD_RGN_SFR && !sfr_hit && !status_hit);
  assign ram_off     = cpu_addr - MMD_RAM_BASE;
  assign dfl_off     = cpu_addr - MMD_DFL_BASE;
  assign match0_addr = sfr_regs[MMD_IDX_MATCH0*8 +: 20];
  assign match1_addr = sfr_regs[MMD_IDX_MATCH1*8 +: 20];
  assign match_en    = sfr_regs[MMD_IDX_MATEN*8 +: 8];

  // ----------------------------------------------------------------
  // internal RAM
  // ----------------------------------------------------------------
  logic [7:0]        ram_mem [RAM_BYTES];
  logic              ram_we;
  logic [RAM_AW-1:0] ram_idx;

  always_comb
  begin
    ram_idx = ram_off[RAM_AW-1:0];
    ram_we  = cpu_wr && (region == MMD_RGN_RAM);
  end

  // no reset on the array: contents are undefined after power up
  always_ff @(posedge clk)
  begin
    if (ram_we)
      ram_mem[ram_idx] <= cpu_wdata;
  end

  // ----------------------------------------------------------------
  // read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] status_reg;

  always_comb
  begin
    rdata_next = 8'h00;
    if (cpu_rd)
    begin
      case (region)
        MMD_RGN_SFR:
          if (status_hit)
            rdata_next = {4'h0, status_reg};
          else
            rdata_next = sfr_rdata;
        MMD_RGN_RAM:  rdata_next = ram_mem[ram_idx];
        MMD_RGN_DFL:  rdata_next = dfl_rdata;
        MMD_RGN_ROM:  rdata_next = rom_rdata;
        default:      rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  assign cpu_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // region selects
  // ----------------------------------------------------------------
  logic        sel_sfr_reg;
  logic        sel_ram_reg;
  logic        sel_dfl_reg;
  logic        sel_rom_reg;
  logic        sel_vec_reg;
  logic        blk_b_reg;
  logic        dfl_wr_reg;
  logic [10:0] dfl_addr_reg;
  logic [7:0]  dfl_wdata_reg;
  logic        sel_sfr_next;
  logic        sel_ram_next;
  logic        sel_dfl_next;
  logic        sel_rom_next;
  logic        sel_vec_next;
  logic        blk_b_next;
  logic        dfl_wr_next;
  logic [10:0] dfl_addr_next;
  logic [7:0]  dfl_wdata_next;

  always_comb
  begin
    sel_sfr_next = 1'b0;
    sel_ram_next = 1'b0;
    sel_dfl_next = 1'b0;
    sel_rom_next = 1'b0;
    sel_vec_next = cpu_rd && vector;
    // empty control offsets are reserved and raise no select
    if (access && !reserved)
    begin
      case (region)
        MMD_RGN_SFR: sel_sfr_next = 1'b1;
        MMD_RGN_RAM: sel_ram_next = 1'b1;
        MMD_RGN_DFL: sel_dfl_next = 1'b1;
        MMD_RGN_ROM: sel_rom_next = 1'b1;
        default:     sel_sfr_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_sfr_reg <= 1'b0;
      sel_ram_reg <= 1'b0;
      sel_dfl_reg <= 1'b0;
      sel_rom_reg <= 1'b0;
      sel_vec_reg <= 1'b0;
    end
    else
    begin
      sel_sfr_reg <= sel_sfr_next;
      sel_ram_reg <= sel_ram_next;
      sel_dfl_reg <= sel_dfl_next;
      sel_rom_reg <= sel_rom_next;
      sel_vec_reg <= sel_vec_next;
    end
  end

  // ----------------------------------------------------------------
  // data flash write port
  // ----------------------------------------------------------------
  always_comb
  begin
    // block, offset and data hold so the flash side may sample late
    blk_b_next     = blk_b_reg;
    dfl_wr_next    = 1'b0;
    dfl_addr_next  = dfl_addr_reg;
    dfl_wdata_next = dfl_wdata_reg;
    if (sel_dfl_next)
    begin
      blk_b_next    = (cpu_addr >= MMD_DFL_B_BASE);
      dfl_addr_next = dfl_off[10:0];
      if (cpu_wr)
      begin
        dfl_wr_next    = 1'b1;
        dfl_wdata_next = cpu_wdata;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      blk_b_reg     <= 1'b0;
      dfl_wr_reg    <= 1'b0;
      dfl_addr_reg  <= 11'h000;
      dfl_wdata_reg <= 8'h00;
    end
    else
    begin
      blk_b_reg     <= blk_b_next;
      dfl_wr_reg    <= dfl_wr_next;
      dfl_addr_reg  <= dfl_addr_next;
      dfl_wdata_reg <= dfl_wdata_next;
    end
  end

  assign sel_sfr    = sel_sfr_reg;
  assign sel_ram    = sel_ram_reg;
  assign sel_dfl    = sel_dfl_reg;
  assign sel_rom    = sel_rom_reg;
  assign sel_vector = sel_vec_reg;
  assign dfl_blk_b  = blk_b_reg;
  assign dfl_wr     = dfl_wr_reg;
  assign dfl_addr   = dfl_addr_reg;
  assign dfl_wdata  = dfl_wdata_reg;

  // ----------------------------------------------------------------
  // address match and debugger area
  // ----------------------------------------------------------------
  logic       m0_reg;
  logic       m1_reg;
  logic       emu_reg;
  logic       m0_next;
  logic       m1_next;
  logic       emu_next;
  logic [3:0] status_next;
  logic [3:0] status_set;
  logic [3:0] status_clr;

  always_comb
  begin
    m0_next  = cpu_rd && match_en[MMD_MATEN_B0] && cpu_addr == match0_addr;
    m1_next  = cpu_rd && match_en[MMD_MATEN_B1] && cpu_addr == match1_addr;
    emu_next = access && emu_area;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      m0_reg  <= 1'b0;
      m1_reg  <= 1'b0;
      emu_reg <= 1'b0;
    end
    else
    begin
      m0_reg  <= m0_next;
      m1_reg  <= m1_next;
      emu_reg <= emu_next;
    end
  end

  // ----------------------------------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------------------------------
  always_comb
  begin
    status_set = 4'h0;
    status_set[MMD_ST_RSV]    = access && reserved;
    status_set[MMD_ST_EMU]    = emu_next;
    status_set[MMD_ST_MATCH0] = m0_next;
    status_set[MMD_ST_MATCH1] = m1_next;
    status_clr  = (cpu_wr && status_hit) ? cpu_wdata[MMD_ST_W-1:0] : 4'h0;
    // a new event in the clearing cycle survives the clear
    status_next = (status_reg & ~status_clr) | status_set;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      status_reg <= 4'h0;
    else
      status_reg <= status_next;
  end

  assign match0     = m0_reg;
  assign match1     = m1_reg;
  assign emu_access = emu_reg;

endmodule : mmd_top

`default_nettype wire

//--- mmd_pkg.sv
// mmd_pkg.sv: constants and types of the memory map decoder
`default_nettype none

package mmd_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [19:0] MMD_ADDR_MIN     = 20'h0_0000;
  localparam logic [19:0] MMD_ADDR_MAX     = 20'hF_FFFF;
  localparam logic [19:0] MMD_SFR_BASE     = 20'h0_0000;
  localparam logic [19:0] MMD_SFR_END      = 20'h0_02FF;
  localparam logic [19:0] MMD_RAM_BASE     = 20'h0_0400;
  localparam logic [19:0] MMD_RAM_END_DEF  = 20'h0_0DFF;
  localparam logic [19:0] MMD_DFL_BASE     = 20'h0_2400;
  localparam logic [19:0] MMD_DFL_B_BASE   = 20'h0_2800;
  localparam logic [19:0] MMD_DFL_END      = 20'h0_2BFF;
  localparam logic [19:0] MMD_ROM_BASE_DEF = 20'h0_4000;
  localparam logic [19:0] MMD_ROM_END      = 20'h0_FFFF;
  localparam logic [19:0] MMD_VEC_BASE     = 20'h0_FFDC;
  localparam logic [19:0] MMD_EMU_BASE     = 20'h2_0000;
  localparam logic [19:0] MMD_EMU_END      = 20'h2_3FFF;

  typedef enum logic [2:0] {MMD_RGN_NONE, MMD_RGN_SFR, MMD_RGN_RAM, MMD_RGN_DFL, MMD_RGN_ROM} mmd_region_e;

  // ----------------------------------------------------------------
  // system control registers
  // ----------------------------------------------------------------
  typedef logic [9:0] mmd_off_t;
  localparam mmd_off_t MMD_OFF_PMODE0 = 10'h004;
  localparam mmd_off_t MMD_OFF_PMODE1 = 10'h005;
  localparam mmd_off_t MMD_OFF_CLKC0  = 10'h006;
  localparam mmd_off_t MMD_OFF_CLKC1  = 10'h007;
  localparam mmd_off_t MMD_OFF_WPROT  = 10'h00A;
  localparam mmd_off_t MMD_OFF_OSD    = 10'h00C;
  localparam mmd_off_t MMD_OFF_WDREF  = 10'h00D;
  localparam mmd_off_t MMD_OFF_WDSTA  = 10'h00E;
  localparam mmd_off_t MMD_OFF_WDCTL  = 10'h00F;
  localparam mmd_off_t MMD_OFF_MATCH0 = 10'h010;
  localparam mmd_off_t MMD_OFF_MATEN  = 10'h013;
  localparam mmd_off_t MMD_OFF_MATCH1 = 10'h014;
  localparam mmd_off_t MMD_OFF_CSPM   = 10'h01C;
  localparam mmd_off_t MMD_OFF_FOSC0  = 10'h023;
  localparam mmd_off_t MMD_OFF_FTRIM  = 10'h024;
  localparam mmd_off_t MMD_OFF_FOSC2  = 10'h025;
  localparam mmd_off_t MMD_OFF_VDET1  = 10'h031;
  localparam mmd_off_t MMD_OFF_VDET2  = 10'h032;
  localparam mmd_off_t MMD_OFF_VMON1  = 10'h036;
  localparam mmd_off_t MMD_OFF_STATUS = 10'h2FF;

  localparam int MMD_SFR_N = 23;
  localparam mmd_off_t MMD_SFR_OFF [MMD_SFR_N] = '{
    MMD_OFF_PMODE0, MMD_OFF_PMODE1, MMD_OFF_CLKC0, MMD_OFF_CLKC1, MMD_OFF_WPROT, MMD_OFF_OSD,
    MMD_OFF_WDREF, MMD_OFF_WDSTA, MMD_OFF_WDCTL,
    MMD_OFF_MATCH0, MMD_OFF_MATCH0 + 10'h001, MMD_OFF_MATCH0 + 10'h002, MMD_OFF_MATEN,
    MMD_OFF_MATCH1, MMD_OFF_MATCH1 + 10'h001, MMD_OFF_MATCH1 + 10'h002,
    MMD_OFF_CSPM, MMD_OFF_FOSC0, MMD_OFF_FTRIM, MMD_OFF_FOSC2,
    MMD_OFF_VDET1, MMD_OFF_VDET2, MMD_OFF_VMON1};
  // undefined reset bits are taken as zero
  localparam logic [7:0] MMD_SFR_RST [MMD_SFR_N] = '{
    8'h00, 8'h00, 8'h68, 8'h20, 8'h00, 8'h04,
    8'h00, 8'h00, 8'h1F,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h08, 8'h00, 8'h00};
  localparam int MMD_IDX_MATCH0 = 9;
  localparam int MMD_IDX_MATEN  = 12;
  localparam int MMD_IDX_MATCH1 = 13;
  localparam int MMD_IDX_FTRIM  = 18;

  // status bits, write one to clear
  localparam int MMD_ST_RSV    = 0;
  localparam int MMD_ST_EMU    = 1;
  localparam int MMD_ST_MATCH0 = 2;
  localparam int MMD_ST_MATCH1 = 3;
  localparam int MMD_ST_W      = 4;
  localparam int MMD_MATEN_B0  = 0;
  localparam int MMD_MATEN_B1  = 1;

endpackage : mmd_pkg

`default_nettype wire

//--- mmd_bus_if.sv
// mmd_bus_if.sv: internal access bus between the decoder top and its parts
`default_nettype none

interface mmd_bus_if;
  logic [19:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  modport master (output addr, output wdata, output wr, output rd);
  modport slave  (input addr, input wdata, input wr, input rd);
endinterface : mmd_bus_if

`default_nettype wire

//--- mmd_region_dec.sv
// mmd_region_dec.sv: combinational region decode of one 20-bit address
`default_nettype none

module mmd_region_dec
  import mmd_pkg::*;
#(
  parameter logic [19:0] ROM_BASE   = MMD_ROM_BASE_DEF,
  parameter logic [19:0] RAM_END    = MMD_RAM_END_DEF,
  parameter bit          HAS_DFLASH = 1'b1
)(
  mmd_bus_if.slave    bus,
  output mmd_region_e region,
  output logic        vector,
  output logic        emu_area
);

  // ranges never overlap, so at most one region is chosen
  always_comb
  begin
    region = MMD_RGN_NONE;
    if (bus.addr <= MMD_SFR_END)
      region = MMD_RGN_SFR;
    else if (bus.addr >= MMD_RAM_BASE && bus.addr <= RAM_END)
      region = MMD_RGN_RAM;
    else if (HAS_DFLASH && bus.addr >= MMD_DFL_BASE && bus.addr <= MMD_DFL_END)
      region = MMD_RGN_DFL;
    else if (bus.addr >= ROM_BASE && bus.addr <= MMD_ROM_END)
      region = MMD_RGN_ROM;
  end

  assign vector   = (bus.addr >= MMD_VEC_BASE) && (bus.addr <= MMD_ROM_END);
  assign emu_area = (bus.addr >= MMD_EMU_BASE) && (bus.addr <= MMD_EMU_END);

endmodule : mmd_region_dec

`default_nettype wire

//--- mmd_sfr_bank.sv
// mmd_sfr_bank.sv: byte storage of the system control registers
`default_nettype none

module mmd_sfr_bank
  import mmd_pkg::*;
#(
  parameter logic [7:0] TRIM_RESET = 8'h00
)(
  input  wire logic               clk,
  input  wire logic               rst,
  mmd_bus_if.slave                bus,
  output logic                    hit,
  output logic [7:0]              rdata,
  output logic [MMD_SFR_N*8-1:0]  regs
);

  genvar g;
  generate
    for (g = 0; g < MMD_SFR_N; g++)
    begin : g_byte
      logic [7:0] byte_reg;
      logic [7:0] byte_next;
      always_comb
      begin
        byte_next = byte_reg;
        if (bus.wr && bus.addr == {10'h000, MMD_SFR_OFF[g]})
          byte_next = bus.wdata;
      end
      always_ff @(posedge clk)
      begin
        if (rst)
          byte_reg <= (g == MMD_IDX_FTRIM) ? TRIM_RESET : MMD_SFR_RST[g];
        else
          byte_reg <= byte_next;
      end
      assign regs[g*8 +: 8] = byte_reg;
    end
  endgenerate

  // unassigned offsets fall through with no hit and no storage
  always_comb
  begin
    hit   = 1'b0;
    rdata = 8'h00;
    for (int i = 0; i < MMD_SFR_N; i++)
    begin
      if (bus.addr == {10'h000, MMD_SFR_OFF[i]})
      begin
        hit   = 1'b1;
        rdata = regs[i*8 +: 8];
      end
    end
  end

endmodule : mmd_sfr_bank

`default_nettype wire

//--- mmd_cpu_model.sv
// mmd_cpu_model.sv: cpu core bus master model driving the decoder
`default_nettype none

module mmd_cpu_model
  import mmd_pkg::*;
(
  input  wire logic       clk,
  output logic [19:0]     addr,
  output logic [7:0]      wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata,
  input  wire logic [4:0] sels
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr  = 20'h0_0000;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // ----------------------------------------------------------------
  // one access: strobe cycle, answer taken in the following cycle
  // ----------------------------------------------------------------
  // reserved and debugger areas are only reached by refusal scenarios
  task automatic acc(input logic w, input logic [19:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic [4:0] s);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b0;
    // stale write data must not look valid
    wdata <= ~d;
    #1;
    q = rdata;
    s = sels;
  endtask : acc
endmodule : mmd_cpu_model

`default_nettype wire

//--- mmd_top_chk.sv
// mmd_top_chk.sv: port-level assertions of the memory map decoder
`default_nettype none

module mmd_top_chk
  import mmd_pkg::*;
#(
  parameter logic [19:0] ROM_BASE = MMD_ROM_BASE_DEF,
  parameter logic [19:0] RAM_END  = MMD_RAM_END_DEF
)(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [19:0] cpu_addr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [7:0]  cpu_rdata,
  input wire logic [7:0]  rom_rdata,
  input wire logic        sel_sfr,
  input wire logic        sel_ram,
  input wire logic        sel_dfl,
  input wire logic        sel_rom,
  input wire logic        sel_vector,
  input wire logic        dfl_blk_b,
  input wire logic        dfl_wr,
  input wire logic [10:0] dfl_addr,
  input wire logic [7:0]  dfl_wdata,
  input wire logic        emu_access
);
  logic acc, in_sfr, in_ram, in_dfl, in_rom, in_vec, in_emu;
  assign acc    = cpu_wr | cpu_rd;
  assign in_sfr = cpu_addr <= MMD_SFR_END;
  assign in_ram = cpu_addr >= MMD_RAM_BASE && cpu_addr <= RAM_END;
  assign in_dfl = cpu_addr >= MMD_DFL_BASE && cpu_addr <= MMD_DFL_END;
  assign in_rom = cpu_addr >= ROM_BASE && cpu_addr <= MMD_ROM_END;
  assign in_vec = cpu_addr >= MMD_VEC_BASE && cpu_addr <= MMD_ROM_END;
  assign in_emu = cpu_addr >= MMD_EMU_BASE && cpu_addr <= MMD_EMU_END;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sel_one_hot: assert property ($onehot0({sel_sfr, sel_ram, sel_dfl, sel_rom}))
    else $error("more than one region select");
  a_sfr_source: assert property (sel_sfr |-> $past(acc && in_sfr))
    else $error("register select without register access");
  a_ram_select: assert property (acc && in_ram |=> sel_ram)
    else $error("ram access without ram select");
  a_rom_select: assert property (cpu_rd && in_rom |=> sel_rom && cpu_rdata == $past(rom_rdata))
    else $error("rom read wrong select or data");
  a_vector_read: assert property (sel_vector == $past(cpu_rd && in_vec))
    else $error("vector select mismatch");
  a_dfl_decode: assert property (acc && in_dfl |=> sel_dfl && dfl_addr == $past(cpu_addr[10:0] - 11'h400)
    && dfl_blk_b == $past(cpu_addr >= MMD_DFL_B_BASE))
    else $error("data flash decode wrong");
  a_dfl_write: assert property (cpu_wr && in_dfl |=> dfl_wr && dfl_wdata == $past(cpu_wdata))
    else $error("data flash write not passed on");
  a_none_reserved: assert property (acc && !(in_sfr || in_ram || in_dfl || in_rom)
    |=> !(sel_sfr || sel_ram || sel_dfl || sel_rom))
    else $error("select raised for reserved address");
  a_rdata_idle: assert property (!cpu_rd |=> cpu_rdata == 8'h00)
    else $error("read data outside read answer");
  a_emu_flag: assert property (emu_access == $past(acc && in_emu))
    else $error("debugger area flag mismatch");
endmodule : mmd_top_chk

bind mmd_top mmd_top_chk #(.ROM_BASE(ROM_BASE), .RAM_END(RAM_END)) mmd_top_chk_inst (
  .clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
  .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .rom_rdata(rom_rdata), .sel_sfr(sel_sfr),
  .sel_ram(sel_ram), .sel_dfl(sel_dfl), .sel_rom(sel_rom), .sel_vector(sel_vector),
  .dfl_blk_b(dfl_blk_b), .dfl_wr(dfl_wr), .dfl_addr(dfl_addr), .dfl_wdata(dfl_wdata),
  .emu_access(emu_access));

`default_nettype wire

//--- tb_mmd_top.sv
// tb_mmd_top.sv: self-checking testbench of the memory map decoder
`default_nettype none

module tb_mmd_top;
  import mmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [4:0] S_NONE = 5'b00000;
  localparam logic [4:0] S_SFR  = 5'b01000;
  localparam logic [4:0] S_RAM  = 5'b00100;
  localparam logic [4:0] S_DFL  = 5'b00010;
  localparam logic [4:0] S_ROM  = 5'b00001;
  localparam logic [4:0] S_VEC  = 5'b10001;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [19:0] cpu_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, rom_rdata, dfl_rdata, dfl_wdata;
  logic        cpu_wr, cpu_rd, sel_sfr, sel_ram, sel_dfl, sel_rom, sel_vector;
  logic        dfl_blk_b, dfl_wr, match0, match1, emu_access;
  logic [10:0] dfl_addr;
  wire logic [4:0] sels = {sel_vector, sel_sfr, sel_ram, sel_dfl, sel_rom};
  int          errors = 0;
  int          samples_checked = 0;

  always #4 clk = ~clk;
  // far memories answer with an address-derived pattern
  assign rom_rdata = cpu_addr[7:0] ^ 8'hA5;
  assign dfl_rdata = cpu_addr[7:0] ^ 8'h3C;

  mmd_top mmd_top_inst (
    .clk(clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .rom_rdata(rom_rdata), .dfl_rdata(dfl_rdata),
    .sel_sfr(sel_sfr), .sel_ram(sel_ram), .sel_dfl(sel_dfl), .sel_rom(sel_rom),
    .sel_vector(sel_vector), .dfl_blk_b(dfl_blk_b), .dfl_wr(dfl_wr), .dfl_addr(dfl_addr),
    .dfl_wdata(dfl_wdata), .match0(match0), .match1(match1), .emu_access(emu_access));

  mmd_cpu_model mmd_cpu_model_inst (
    .clk(clk), .addr(cpu_addr), .wdata(cpu_wdata), .wr(cpu_wr), .rd(cpu_rd),
    .rdata(cpu_rdata), .sels(sels));

  // ----------------------------------------------------------------
  // shared checks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic op(input logic w, input logic [19:0] a, input logic [7:0] d,
                    input logic [7:0] eq, input logic [4:0] es);
    logic [7:0] q;
    logic [4:0] s;
    mmd_cpu_model_inst.acc(w, a, d, q, s);
    chk("cpu_rdata", eq, q);
    chk("selects", es, s);
  endtask : op

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals();
    for (int i = 0; i < MMD_SFR_N; i++)
      op(1'b0, {10'h000, MMD_SFR_OFF[i]}, 8'h00, MMD_SFR_RST[i], S_SFR);
  endtask : t_reset_vals

  task automatic t_reg_rw();
    logic [19:0] rsv [3] = '{20'h0_0008, 20'h0_0017, 20'h0_02FE};
    for (int i = 0; i < MMD_SFR_N; i++)
    begin
      op(1'b1, {10'h000, MMD_SFR_OFF[i]}, 8'hC3 ^ 8'(i), 8'h00, S_SFR);
      op(1'b0, {10'h000, MMD_SFR_OFF[i]}, 8'h00, 8'hC3 ^ 8'(i), S_SFR);
    end
    foreach (rsv[i])
    begin
      op(1'b1, rsv[i], 8'h5A, 8'h00, S_NONE);
      op(1'b0, rsv[i], 8'h00, 8'h00, S_NONE);
    end
    op(1'b1, 20'h0_0300, 8'h77, 8'h00, S_NONE);
    op(1'b0, 20'h0_0300, 8'h00, 8'h00, S_NONE);
  endtask : t_reg_rw

  task automatic t_ram();
    op(1'b1, MMD_RAM_BASE, 8'hAA, 8'h00, S_RAM);
    op(1'b1, MMD_RAM_END_DEF, 8'h55, 8'h00, S_RAM);
    op(1'b0, MMD_RAM_BASE, 8'h00, 8'hAA, S_RAM);
    op(1'b0, MMD_RAM_END_DEF, 8'h00, 8'h55, S_RAM);
    op(1'b0, MMD_RAM_END_DEF + 20'h1, 8'h00, 8'h00, S_NONE);
    op(1'b0, MMD_RAM_BASE - 20'h1, 8'h00, 8'h00, S_NONE);
  endtask : t_ram

  task automatic t_rom();
    op(1'b0, 20'h0_4000, 8'h00, 8'h00 ^ 8'hA5, S_ROM);
    op(1'b0, 20'h0_3FFF, 8'h00, 8'h00, S_NONE);
    op(1'b0, 20'h0_FFDB, 8'h00, 8'hDB ^ 8'hA5, S_ROM);
    op(1'b0, 20'h0_FFDC, 8'h00, 8'hDC ^ 8'hA5, S_VEC);
    op(1'b0, 20'h0_FFFF, 8'h00, 8'hFF ^ 8'hA5, S_VEC);
    op(1'b0, 20'h1_0000, 8'h00, 8'h00, S_NONE);
  endtask : t_rom

  task automatic t_dfl();
    op(1'b1, 20'h0_2801, 8'h11, 8'h00, S_DFL);
    chk("dfl_wr", 1'b1, dfl_wr);
    chk("dfl_addr", 11'h401, dfl_addr);
    chk("dfl_blk_b", 1'b1, dfl_blk_b);
    chk("dfl_wdata", 8'h11, dfl_wdata);
    op(1'b0, 20'h0_2400, 8'h00, 8'h00 ^ 8'h3C, S_DFL);
    chk("dfl_wr", 1'b0, dfl_wr);
    chk("dfl_addr", 11'h000, dfl_addr);
    chk("dfl_blk_b", 1'b0, dfl_blk_b);
    op(1'b0, 20'h0_2BFF, 8'h00, 8'hFF ^ 8'h3C, S_DFL);
    chk("dfl_addr", 11'h7FF, dfl_addr);
    op(1'b0, 20'h0_2C00, 8'h00, 8'h00, S_NONE);
    op(1'b0, 20'h0_23FF, 8'h00, 8'h00, S_NONE);
  endtask : t_dfl

  task automatic t_far();
    logic [19:0] a [5] = '{20'h2_0000, 20'h2_3FFF, 20'h2_4000, 20'h1_FFFF, 20'hF_FFFF};
    logic        e [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    foreach (a[i])
    begin
      op(1'b1, a[i], 8'h99, 8'h00, S_NONE);
      chk("emu_access", e[i], emu_access);
      op(1'b0, a[i], 8'h00, 8'h00, S_NONE);
    end
  endtask : t_far

  task automatic t_status_match();
    op(1'b0, 20'h0_02FF, 8'h00, 8'h03, S_SFR);
    op(1'b1, 20'h0_02FF, 8'h0F, 8'h00, S_SFR);
    op(1'b0, 20'h0_02FF, 8'h00, 8'h00, S_SFR);
    op(1'b1, 20'h0_0010, 8'h21, 8'h00, S_SFR);
    op(1'b1, 20'h0_0011, 8'h43, 8'h00, S_SFR);
    op(1'b1, 20'h0_0012, 8'hF0, 8'h00, S_SFR);
    op(1'b1, 20'h0_0014, 8'h00, 8'h00, S_SFR);
    op(1'b1, 20'h0_0015, 8'h04, 8'h00, S_SFR);
    op(1'b1, 20'h0_0016, 8'h00, 8'h00, S_SFR);
    op(1'b1, 20'h0_0013, 8'h01, 8'h00, S_SFR);
    op(1'b0, 20'h0_4321, 8'h00, 8'h21 ^ 8'hA5, S_ROM);
    chk("match0", 1'b1, match0);
    chk("match1", 1'b0, match1);
    op(1'b1, 20'h0_4321, 8'h00, 8'h00, S_ROM);
    chk("match0", 1'b0, match0);
    op(1'b0, 20'h0_0400, 8'h00, 8'hAA, S_RAM);
    chk("match1", 1'b0, match1);
    op(1'b1, 20'h0_0013, 8'h02, 8'h00, S_SFR);
    op(1'b0, 20'h0_0400, 8'h00, 8'hAA, S_RAM);
    chk("match1", 1'b1, match1);
    chk("match0", 1'b0, match0);
    op(1'b0, 20'h0_02FF, 8'h00, 8'h0C, S_SFR);
  endtask : t_status_match

  initial
  begin
    #400us;
    errors++;
    tally_and_finish();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_vals();
    t_reg_rw();
    t_ram();
    t_rom();
    t_dfl();
    t_far();
    t_status_match();
    tally_and_finish();
  end
endmodule : tb_mmd_top

`default_nettype wire
